// >>> logic/ssl_regs.svh
// Register offsets, field positions, reset values and timing counts of the status LED block
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH

`define SSL_ADR_W            8
`define SSL_OFS_CTRL         8'h00
`define SSL_OFS_CONTACT      8'h04
`define SSL_OFS_STATUS       8'h08
`define SSL_OFS_MASK         8'h0c
`define SSL_OFS_LEDSTATE     8'h10

`define SSL_CTRL_IDENT_BIT   0
`define SSL_CTRL_RESET       32'h0000_0000
`define SSL_CONTACT_RESET    10'h000
`define SSL_MASK_RESET       4'h0

`define SSL_EV_FAULT_BIT     0
`define SSL_EV_SUPPLY_BIT    1
`define SSL_EV_DISC_BIT      2
`define SSL_EV_FWDONE_BIT    3

`define SSL_LS_GREEN_BIT     0
`define SSL_LS_RED_BIT       1
`define SSL_LS_DISC_LSB      8

`define SSL_CLK_HZ           10000000
`define SSL_SLOW_HALF_MS     1000
`define SSL_FAST_HALF_MS     250
`define SSL_IDENT_HALF_MS    500
`define SSL_SLOW_HALF_CYC    (`SSL_CLK_HZ / 1000 * `SSL_SLOW_HALF_MS)
`define SSL_FAST_HALF_CYC    (`SSL_CLK_HZ / 1000 * `SSL_FAST_HALF_MS)
`define SSL_IDENT_HALF_CYC   (`SSL_CLK_HZ / 1000 * `SSL_IDENT_HALF_MS)

`endif

// >>> logic/ssl_pkg.sv
// Types shared by the status LED block
package ssl_pkg;
	typedef enum logic [1:0] {SSL_OFF, SSL_GREEN, SSL_RED, SSL_ORANGE} ssl_color_e;
	typedef logic [23:0] ssl_cnt_t;
endpackage

// >>> logic/ssl_flash_if.sv
// Flash phase signals passed from the prescaler to the LED logic
`timescale 1ns/100ps
`default_nettype none
interface ssl_flash_if;
	logic slow_ph;
	logic fast_ph;
	logic ident_ph;
	modport gen (output slow_ph, output fast_ph, output ident_ph);
	modport use_ph (input slow_ph, input fast_ph, input ident_ph);
endinterface
`default_nettype wire

// >>> logic/ssl_flash.sv
// Prescaler producing symmetric flash phases from the system clock
`include "ssl_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module ssl_flash
	import ssl_pkg::*;
#(
	parameter int SLOW_HALF_CYC  = `SSL_SLOW_HALF_CYC,
	parameter int FAST_HALF_CYC  = `SSL_FAST_HALF_CYC,
	parameter int IDENT_HALF_CYC = `SSL_IDENT_HALF_CYC
) (
	input  wire logic   clk,
	input  wire logic   rst,
	ssl_flash_if.gen    ph
);
	ssl_cnt_t slow_cnt_ff, fast_cnt_ff, ident_cnt_ff;
	ssl_cnt_t nxt_slow_cnt, nxt_fast_cnt, nxt_ident_cnt;
	logic     slow_ff, fast_ff, ident_ff;
	logic     nxt_slow, nxt_fast, nxt_ident;

	// Each colour lasts exactly one half period
	always_comb begin
		nxt_slow_cnt  = slow_cnt_ff + 24'h1;
		nxt_slow      = slow_ff;
		nxt_fast_cnt  = fast_cnt_ff + 24'h1;
		nxt_fast      = fast_ff;
		nxt_ident_cnt = ident_cnt_ff + 24'h1;
		nxt_ident     = ident_ff;
		if (slow_cnt_ff == ssl_cnt_t'(SLOW_HALF_CYC - 1)) begin
			nxt_slow_cnt = '0;
			nxt_slow     = ~slow_ff;
		end
		if (fast_cnt_ff == ssl_cnt_t'(FAST_HALF_CYC - 1)) begin
			nxt_fast_cnt = '0;
			nxt_fast     = ~fast_ff;
		end
		if (ident_cnt_ff == ssl_cnt_t'(IDENT_HALF_CYC - 1)) begin
			nxt_ident_cnt = '0;
			nxt_ident     = ~ident_ff;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slow_cnt_ff  <= '0;
			fast_cnt_ff  <= '0;
			ident_cnt_ff <= '0;
			slow_ff      <= 1'b1;
			fast_ff      <= 1'b1;
			ident_ff     <= 1'b1;
		end else begin
			slow_cnt_ff  <= nxt_slow_cnt;
			fast_cnt_ff  <= nxt_fast_cnt;
			ident_cnt_ff <= nxt_ident_cnt;
			slow_ff      <= nxt_slow;
			fast_ff      <= nxt_fast;
			ident_ff     <= nxt_ident;
		end
	end

	assign ph.slow_ph  = slow_ff;
	assign ph.fast_ph  = fast_ff;
	assign ph.ident_ph = ident_ff;
endmodule // ssl_flash
`default_nettype wire

// >>> logic/ssl_led_top.sv
// Status LED logic of a fail-safe terminal I/O module with a Wishbone register slave
// Contract
// - Ready green when operational and link cyclic
// - Ready orange while link is being set up
// - Ready red while FAULT_ACTIVE, unless download, download complete or identify is active
// - Firmware download flashes green/red at 0.5 Hz
// - Download complete flashes green/red at 2 Hz
// - Identify flashes green/orange or red/orange
// - Switchable supply LEDs on healthy, red on fault
// - Fixed supply LED on healthy, red on fault
// - NC/NC pair: differing channels light second red
// - NC/NC pair: both inactive leaves both dark
// - NC/NC pair: both active lights both green
// - NC/NO pair: equal channels light second red
// - NC/NO pair: first off, second on, dark
// - NC/NO pair: first on, second off, green
// - Plain input LED green when active
// - Safe output LED green while output active
// - Readback LED green when both lines inactive
`include "ssl_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module ssl_led_top
	import ssl_pkg::*;
#(
	parameter int SLOW_HALF_CYC  = `SSL_SLOW_HALF_CYC,
	parameter int FAST_HALF_CYC  = `SSL_FAST_HALF_CYC,
	parameter int IDENT_HALF_CYC = `SSL_IDENT_HALF_CYC
) (
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	output logic             IRQ,
	input  wire logic        LINK_CYCLIC,
	input  wire logic        LINK_SETUP,
	input  wire logic        FAULT_ACTIVE,
	input  wire logic        FW_DOWNLOADING,
	input  wire logic        FW_DONE,
	input  wire logic        SUPPLY_A_FAULT,
	input  wire logic        SUPPLY_B_FAULT,
	input  wire logic        SUPPLY_FIX_FAULT,
	input  wire logic [19:0] DUAL_CHANNEL_SAFE_INPUT,
	input  wire logic [3:0]  PLAIN_DIGITAL_INPUT,
	input  wire logic [3:0]  SAFE_OUT_POS,
	input  wire logic [3:0]  SAFE_OUT_NEG,
	output logic             READY_GREEN,
	output logic             READY_RED,
	output logic             SUPPLY_A_ON,
	output logic             SUPPLY_A_RED,
	output logic             SUPPLY_B_ON,
	output logic             SUPPLY_B_RED,
	output logic             SUPPLY_FIX_ON,
	output logic             SUPPLY_FIX_RED,
	output logic      [19:0] SAFE_IN_GREEN,
	output logic      [19:0] SAFE_IN_RED,
	output logic      [3:0]  PLAIN_IN_GREEN,
	output logic      [3:0]  SAFE_OUT_GREEN,
	output logic      [3:0]  READBACK_GREEN
);
	ssl_flash_if flash ();

	ssl_flash #(
		.SLOW_HALF_CYC  (SLOW_HALF_CYC),
		.FAST_HALF_CYC  (FAST_HALF_CYC),
		.IDENT_HALF_CYC (IDENT_HALF_CYC)
	) u_flash (
		.clk (REF_CLK),
		.rst (RESET),
		.ph  (flash.gen)
	);

	// Terminal pins are asynchronous; only the second stage is read
	logic [31:0] sync1_ff, sync2_ff;
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {SAFE_OUT_NEG, SAFE_OUT_POS, PLAIN_DIGITAL_INPUT, DUAL_CHANNEL_SAFE_INPUT};
			sync2_ff <= sync1_ff;
		end
	end
	logic [19:0] safe_s;
	logic [3:0]  plain_s, pos_s, neg_s;
	assign safe_s  = sync2_ff[19:0];
	assign plain_s = sync2_ff[23:20];
	assign pos_s   = sync2_ff[27:24];
	assign neg_s   = sync2_ff[31:28];

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Pair decode: {first green, second green, second red}
	function automatic logic [2:0] pair_decode(input logic a, input logic b, input logic no_contact);
		logic b_eff;
		logic disc;
		b_eff = b ^ no_contact;
		disc  = a ^ b_eff;
		return {a & b_eff, a & b_eff, disc};
	endfunction

	// Register bus
	logic        req, wr;
	logic        ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        ident_ff, nxt_ident;
	logic [9:0]  contact_ff, nxt_contact;
	logic [3:0]  status_ff, nxt_status;
	logic [3:0]  mask_ff, nxt_mask;
	logic        irq_ff, nxt_irq;
	logic [3:0]  events;
	logic [3:0]  clr;
	logic [31:0] merged, ctrl_m, contact_m, mask_m;
	// A literal cannot be bit-selected, so the reset word is held as a constant
	localparam logic [31:0] ctrl_rst = `SSL_CTRL_RESET;
	logic [9:0]  disc_v;
	logic        rdy_g_ff, rdy_r_ff;

	assign req    = WB_CYC_I & WB_STB_I & ~ack_ff;
	assign wr     = WB_CYC_I & WB_STB_I & WB_WE_I & ack_ff;
	assign merged = lane_merge(32'h0000_0000, WB_DAT_I, WB_SEL_I);
	assign ctrl_m    = lane_merge({31'h0, ident_ff}, WB_DAT_I, WB_SEL_I);
	assign contact_m = lane_merge({22'h0, contact_ff}, WB_DAT_I, WB_SEL_I);
	assign mask_m    = lane_merge({28'h0, mask_ff}, WB_DAT_I, WB_SEL_I);

	always_comb begin
		nxt_ack     = req;
		nxt_rdata   = rdata_ff;
		nxt_ident   = ident_ff;
		nxt_contact = contact_ff;
		nxt_mask    = mask_ff;
		clr         = 4'h0;
		if (req) begin
			if (WB_ADR_I == `SSL_OFS_CTRL) begin
				nxt_rdata = {31'h0, ident_ff};
			end else if (WB_ADR_I == `SSL_OFS_CONTACT) begin
				nxt_rdata = {22'h0, contact_ff};
			end else if (WB_ADR_I == `SSL_OFS_STATUS) begin
				nxt_rdata = {28'h0, status_ff};
			end else if (WB_ADR_I == `SSL_OFS_MASK) begin
				nxt_rdata = {28'h0, mask_ff};
			end else if (WB_ADR_I == `SSL_OFS_LEDSTATE) begin
				nxt_rdata = {14'h0, disc_v, 6'h0, rdy_r_ff, rdy_g_ff};
			end else begin
				nxt_rdata = 32'h0000_0000;
			end
		end
		if (wr) begin
			if (WB_ADR_I == `SSL_OFS_CTRL) begin
				nxt_ident = ctrl_m[`SSL_CTRL_IDENT_BIT];
			end else if (WB_ADR_I == `SSL_OFS_CONTACT) begin
				nxt_contact = contact_m[9:0];
			end else if (WB_ADR_I == `SSL_OFS_STATUS) begin
				clr = merged[3:0];
			end else if (WB_ADR_I == `SSL_OFS_MASK) begin
				nxt_mask = mask_m[3:0];
			end
		end
		// Set beats clear so an event in the clearing cycle survives
		nxt_status = (status_ff & ~clr) | events;
		nxt_irq    = |(nxt_status & nxt_mask);
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			ack_ff     <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			ident_ff   <= ctrl_rst[`SSL_CTRL_IDENT_BIT];
			contact_ff <= `SSL_CONTACT_RESET;
			status_ff  <= 4'h0;
			mask_ff    <= `SSL_MASK_RESET;
			irq_ff     <= 1'b0;
		end else begin
			ack_ff     <= nxt_ack;
			rdata_ff   <= nxt_rdata;
			ident_ff   <= nxt_ident;
			contact_ff <= nxt_contact;
			status_ff  <= nxt_status;
			mask_ff    <= nxt_mask;
			irq_ff     <= nxt_irq;
		end
	end

	assign WB_ACK_O = ack_ff;
	assign WB_DAT_O = rdata_ff;
	assign IRQ      = irq_ff;

	// Ready indicator and event edges
	ssl_color_e  ready_ff, nxt_ready;
	logic        nxt_rdy_g, nxt_rdy_r;
	logic        ident_red_ff, nxt_ident_red;
	logic [4:0]  prev_ff, nxt_prev;
	logic        supply_any;

	assign supply_any = SUPPLY_A_FAULT | SUPPLY_B_FAULT | SUPPLY_FIX_FAULT;

	always_comb begin
		nxt_prev      = {ident_ff, FW_DONE, |disc_v, supply_any, FAULT_ACTIVE};
		events        = nxt_prev[3:0] & ~prev_ff[3:0];
		nxt_ident_red = ident_red_ff;
		// Pair choice is frozen at the moment identify switches on
		if (ident_ff & ~prev_ff[4]) begin
			nxt_ident_red = (ready_ff == SSL_RED);
		end
		if (FW_DONE) begin
			nxt_ready = flash.fast_ph ? SSL_GREEN : SSL_RED;
		end else if (FW_DOWNLOADING) begin
			nxt_ready = flash.slow_ph ? SSL_GREEN : SSL_RED;
		end else if (ident_ff) begin
			if (flash.ident_ph) begin
				nxt_ready = SSL_ORANGE;
			end else begin
				nxt_ready = nxt_ident_red ? SSL_RED : SSL_GREEN;
			end
		end else if (FAULT_ACTIVE) begin
			nxt_ready = SSL_RED;
		end else if (LINK_CYCLIC) begin
			nxt_ready = SSL_GREEN;
		end else if (LINK_SETUP) begin
			nxt_ready = SSL_ORANGE;
		end else begin
			nxt_ready = SSL_OFF;
		end
		case (nxt_ready)
			SSL_GREEN: begin
				nxt_rdy_g = 1'b1;
				nxt_rdy_r = 1'b0;
			end
			SSL_RED: begin
				nxt_rdy_g = 1'b0;
				nxt_rdy_r = 1'b1;
			end
			SSL_ORANGE: begin
				nxt_rdy_g = 1'b1;
				nxt_rdy_r = 1'b1;
			end
			default: begin
				nxt_rdy_g = 1'b0;
				nxt_rdy_r = 1'b0;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			ready_ff     <= SSL_OFF;
			rdy_g_ff     <= 1'b0;
			rdy_r_ff     <= 1'b0;
			ident_red_ff <= 1'b0;
			prev_ff      <= 5'h00;
		end else begin
			ready_ff     <= nxt_ready;
			rdy_g_ff     <= nxt_rdy_g;
			rdy_r_ff     <= nxt_rdy_r;
			ident_red_ff <= nxt_ident_red;
			prev_ff      <= nxt_prev;
		end
	end

	assign READY_GREEN = rdy_g_ff;
	assign READY_RED   = rdy_r_ff;

	// Terminal and supply LEDs
	logic [19:0] nxt_safe_g, nxt_safe_r;
	logic [5:0]  nxt_sup, sup_ff;
	logic [19:0] safe_g_ff, safe_r_ff;
	logic [3:0]  plain_ff, out_ff, rb_ff;

	genvar gp;
	generate
		for (gp = 0; gp < 10; gp++) begin : g_pair
			logic [2:0] dec;
			assign dec                  = pair_decode(safe_s[2*gp], safe_s[2*gp+1], contact_ff[gp]);
			assign nxt_safe_g[2*gp]     = dec[2];
			assign nxt_safe_g[2*gp+1]   = dec[1];
			assign nxt_safe_r[2*gp]     = 1'b0;
			assign nxt_safe_r[2*gp+1]   = dec[0];
			assign disc_v[gp]           = dec[0];
		end
	endgenerate

	always_comb begin
		nxt_sup = {~SUPPLY_A_FAULT, SUPPLY_A_FAULT, ~SUPPLY_B_FAULT, SUPPLY_B_FAULT,
			~SUPPLY_FIX_FAULT, SUPPLY_FIX_FAULT};
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			safe_g_ff <= '0;
			safe_r_ff <= '0;
			plain_ff  <= 4'h0;
			out_ff    <= 4'h0;
			rb_ff     <= 4'h0;
			sup_ff    <= 6'h00;
		end else begin
			safe_g_ff <= nxt_safe_g;
			safe_r_ff <= nxt_safe_r;
			plain_ff  <= plain_s;
			out_ff    <= pos_s;
			rb_ff     <= ~(pos_s | neg_s);
			sup_ff    <= nxt_sup;
		end
	end

	assign SAFE_IN_GREEN  = safe_g_ff;
	assign SAFE_IN_RED    = safe_r_ff;
	assign PLAIN_IN_GREEN = plain_ff;
	assign SAFE_OUT_GREEN = out_ff;
	assign READBACK_GREEN = rb_ff;
	assign SUPPLY_A_ON    = sup_ff[5];
	assign SUPPLY_A_RED   = sup_ff[4];
	assign SUPPLY_B_ON    = sup_ff[3];
	assign SUPPLY_B_RED   = sup_ff[2];
	assign SUPPLY_FIX_ON  = sup_ff[1];
	assign SUPPLY_FIX_RED = sup_ff[0];

	// Checks
	sequence s_wb_req;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence s_wb_ans;
		WB_ACK_O ##1 !WB_ACK_O;
	endsequence
	property p_wb_ack;
		@(posedge REF_CLK) disable iff (RESET) s_wb_req |=> s_wb_ans;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("ack not one cycle after request");
	property p_fault_red;
		@(posedge REF_CLK) disable iff (RESET)
		(FAULT_ACTIVE && !FW_DONE && !FW_DOWNLOADING && !ident_ff) |=> (READY_RED && !READY_GREEN);
	endproperty
	a_fault_red: assert property (p_fault_red) else $error("fault not shown red");
	property p_cyclic_green;
		@(posedge REF_CLK) disable iff (RESET)
		(LINK_CYCLIC && !FAULT_ACTIVE && !FW_DONE && !FW_DOWNLOADING && !ident_ff)
		|=> (READY_GREEN && !READY_RED);
	endproperty
	a_cyclic_green: assert property (p_cyclic_green) else $error("cyclic link not green");
	property p_setup_orange;
		@(posedge REF_CLK) disable iff (RESET)
		(LINK_SETUP && !LINK_CYCLIC && !FAULT_ACTIVE && !FW_DONE && !FW_DOWNLOADING && !ident_ff)
		|=> (READY_GREEN && READY_RED);
	endproperty
	a_setup_orange: assert property (p_setup_orange) else $error("link setup not orange");
	property p_dl_flash;
		@(posedge REF_CLK) disable iff (RESET)
		(FW_DOWNLOADING && !FW_DONE) |=> (READY_GREEN == $past(flash.slow_ph) && READY_RED != READY_GREEN);
	endproperty
	a_dl_flash: assert property (p_dl_flash) else $error("download flash wrong");
	property p_done_flash;
		@(posedge REF_CLK) disable iff (RESET)
		FW_DONE |=> (READY_GREEN == $past(flash.fast_ph) && READY_RED != READY_GREEN);
	endproperty
	a_done_flash: assert property (p_done_flash) else $error("done flash wrong");
	property p_ident_orange;
		@(posedge REF_CLK) disable iff (RESET)
		(ident_ff && !FW_DONE && !FW_DOWNLOADING && flash.ident_ph) |=> (READY_GREEN && READY_RED);
	endproperty
	a_ident_orange: assert property (p_ident_orange) else $error("identify not orange");
	property p_supply;
		@(posedge REF_CLK) disable iff (RESET)
		SUPPLY_A_FAULT |=> (SUPPLY_A_RED && !SUPPLY_A_ON);
	endproperty
	a_supply: assert property (p_supply) else $error("supply fault not red");
	property p_pair0;
		@(posedge REF_CLK) disable iff (RESET)
		((safe_s[0] ^ safe_s[1] ^ contact_ff[0])) |=> SAFE_IN_RED[1];
	endproperty
	a_pair0: assert property (p_pair0) else $error("pair discrepancy not red");
	property p_readback;
		@(posedge REF_CLK) disable iff (RESET)
		(pos_s[0] || neg_s[0]) |=> !READBACK_GREEN[0];
	endproperty
	a_readback: assert property (p_readback) else $error("readback lit with active line");
	property p_irq;
		@(posedge REF_CLK) disable iff (RESET)
		(events[0] && mask_ff[0] && $stable(mask_ff)) |=> IRQ && status_ff[0];
	endproperty
	a_irq: assert property (p_irq) else $error("event lost or irq missing");
endmodule // ssl_led_top
`default_nettype wire

// >>> verif/ssl_panel_model.sv
// Terminal and front panel model: wires the terminal pins and decodes the ready LED colour
`timescale 1ns/100ps
`default_nettype none
module ssl_panel_model
	import ssl_pkg::*;
(
	input  wire logic [9:0]  first_ch,
	input  wire logic [9:0]  second_ch,
	output logic      [19:0] pair_pins,
	input  wire logic        ready_green,
	input  wire logic        ready_red,
	output ssl_color_e       ready_color
);
	// Each pair sits on two neighbouring terminals, first channel on the even one
	always_comb begin
		for (int i = 0; i < 10; i++) begin
			pair_pins[2*i]   = first_ch[i];
			pair_pins[2*i+1] = second_ch[i];
		end
	end
	// A two-colour LED lit in both colours looks orange
	always_comb begin
		ready_color = ssl_color_e'({ready_red, ready_green});
	end
endmodule // ssl_panel_model
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench of the status LED block
`include "ssl_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import ssl_pkg::*;
	logic clk, rst, cyc, stb, we, ack, irq;
	logic [7:0] adr;
	logic [3:0] sel, plain, pos, neg, pl_g, so_g, rb_g;
	logic [31:0] dat_w, dat_r, q;
	logic lk_cyc, lk_set, flt, fw_dl, fw_dn, fa, fb, ff;
	logic rg, rr, a_on, a_red, b_on, b_red, f_on, f_red;
	logic [9:0] first_ch, second_ch;
	logic [19:0] pins, in_g, in_r;
	ssl_color_e col;
	int num_errors, cmp_count, g, r, o;
	ssl_led_top #(.SLOW_HALF_CYC(8), .FAST_HALF_CYC(4), .IDENT_HALF_CYC(6)) dut (
		.REF_CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
		.IRQ(irq), .LINK_CYCLIC(lk_cyc), .LINK_SETUP(lk_set), .FAULT_ACTIVE(flt),
		.FW_DOWNLOADING(fw_dl), .FW_DONE(fw_dn), .SUPPLY_A_FAULT(fa), .SUPPLY_B_FAULT(fb),
		.SUPPLY_FIX_FAULT(ff), .DUAL_CHANNEL_SAFE_INPUT(pins), .PLAIN_DIGITAL_INPUT(plain),
		.SAFE_OUT_POS(pos), .SAFE_OUT_NEG(neg), .READY_GREEN(rg), .READY_RED(rr),
		.SUPPLY_A_ON(a_on), .SUPPLY_A_RED(a_red), .SUPPLY_B_ON(b_on), .SUPPLY_B_RED(b_red),
		.SUPPLY_FIX_ON(f_on), .SUPPLY_FIX_RED(f_red), .SAFE_IN_GREEN(in_g), .SAFE_IN_RED(in_r),
		.PLAIN_IN_GREEN(pl_g), .SAFE_OUT_GREEN(so_g), .READBACK_GREEN(rb_g));
	ssl_panel_model panel (.first_ch(first_ch), .second_ch(second_ch), .pair_pins(pins),
		.ready_green(rg), .ready_red(rr), .ready_color(col));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic complete_run;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Holds the request until ack is seen, so no wait-state count is assumed
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d;
		// Ack and read data are taken at the rising edge, before the slave updates them
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = dat_r;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task automatic look(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic flash(input int n);
		g = 0; r = 0; o = 0;
		repeat (n) begin
			@(negedge clk);
			g += int'(rg === 1'b1);
			r += int'(rr === 1'b1);
			o += int'(rg === rr);
		end
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		complete_run();
	end
	initial begin
		logic [2:0] rt [4];
		ssl_color_e re [4];
		logic a, b, c, be;
		rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hf; dat_w = 32'h0;
		{lk_cyc, lk_set, flt, fw_dl, fw_dn, fa, fb, ff} = 8'h00;
		first_ch = 10'h000; second_ch = 10'h000; plain = 4'h0; pos = 4'h0; neg = 4'h0;
		num_errors = 0; cmp_count = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, `SSL_OFS_CONTACT, 32'h0, q); chk("contact reset", q, 32'h0);
		wb(1'b0, `SSL_OFS_CTRL, 32'h0, q); chk("ctrl reset", q, `SSL_CTRL_RESET);
		wb(1'b0, 8'h20, 32'h0, q); chk("unmapped read", q, 32'h0);
		wb(1'b1, `SSL_OFS_MASK, 32'h1, q);
		@(posedge clk); flt <= 1'b1;
		look(3); chk("irq unmasked", {31'h0, irq}, 32'h1);
		wb(1'b0, `SSL_OFS_STATUS, 32'h0, q); chk("status fault", q, 32'h1);
		wb(1'b0, `SSL_OFS_LEDSTATE, 32'h0, q); chk("ledstate red", q & 32'h3, 32'h2);
		wb(1'b1, `SSL_OFS_MASK, 32'h0, q); look(2); chk("irq masked", {31'h0, irq}, 32'h0);
		wb(1'b1, `SSL_OFS_MASK, 32'h1, q);
		wb(1'b1, `SSL_OFS_STATUS, 32'hf, q); look(2); chk("irq cleared", {31'h0, irq}, 32'h0);
		$display("interrupt test done");
		rt = '{3'b100, 3'b010, 3'b111, 3'b000};
		re = '{SSL_GREEN, SSL_ORANGE, SSL_RED, SSL_OFF};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk); {lk_cyc, lk_set, flt} <= rt[i];
			look(3); chk("ready colour", {30'h0, col}, {30'h0, re[i]});
		end
		@(posedge clk); flt <= 1'b1;
		wb(1'b1, `SSL_OFS_CTRL, 32'h1, q);
		look(1); flash(12); chk("ident red", r, 12); chk("ident green", g, 6);
		wb(1'b1, `SSL_OFS_CTRL, 32'h0, q);
		@(posedge clk); flt <= 1'b0; lk_cyc <= 1'b1;
		wb(1'b1, `SSL_OFS_CTRL, 32'h1, q);
		look(1); flash(12); chk("ident green", g, 12); chk("ident red", r, 6);
		@(posedge clk); fw_dl <= 1'b1;
		look(2); flash(16); chk("dl green", g, 8); chk("dl red", r, 8); chk("dl mixed", o, 0);
		@(posedge clk); fw_dn <= 1'b1;
		look(2); flash(8); chk("done green", g, 4); chk("done red", r, 4); chk("done mixed", o, 0);
		$display("ready test done");
		for (int k = 0; k < 8; k++) begin
			@(posedge clk); {fa, fb, ff} <= k[2:0];
			look(2);
			chk("supply a", {a_on, a_red}, {~k[2], k[2]});
			chk("supply b", {b_on, b_red}, {~k[1], k[1]});
			chk("supply fixed", {f_on, f_red}, {~k[0], k[0]});
		end
		// Fault, supply and download-complete edges since the last clear
		wb(1'b0, `SSL_OFS_STATUS, 32'h0, q);
		chk("status events", q, 32'h0000_000b);
		$display("supply test done");
		for (int k = 0; k < 8; k++) begin
			{c, b, a} = k[2:0];
			if (k == 0 || k == 4) wb(1'b1, `SSL_OFS_CONTACT, {22'h0, {10{c}}}, q);
			be = b ^ c;
			@(posedge clk); first_ch <= {10{a}}; second_ch <= {10{b}};
			look(5);
			chk("pair red", in_r, {10{a ^ be, 1'b0}});
			chk("pair green", in_g, {20{a & be}});
			wb(1'b0, `SSL_OFS_LEDSTATE, 32'h0, q);
			chk("pair disc", q[17:8], {10{a ^ be}});
		end
		$display("pair test done");
		for (int k = 0; k < 16; k += 5) begin
			@(posedge clk); plain <= k[3:0]; pos <= k[3:0]; neg <= k[3:0] ^ 4'h3;
			look(5);
			chk("plain", pl_g, k[3:0]);
			chk("safe out", so_g, k[3:0]);
			chk("readback", rb_g, 4'(~(k[3:0] | (k[3:0] ^ 4'h3))));
		end
		$display("terminal test done");
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
